/* bench/exec_unit_model.sv */
// Execution unit model that writes results after a set latency
`timescale 1ns/1ps
`default_nettype none
module exec_unit_model (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Operation start
    input  wire logic                  start,
    input  wire logic [3:0]            lat,
    input  wire regfile_pkg::operand_t dst,
    input  wire logic [31:0]           result,
    input  wire logic                  completes,
    // Result write
    output logic                       wr_en,
    output regfile_pkg::operand_t      wr_sel,
    output logic      [31:0]           wr_data,
    output logic                       wr_completes
);
    import regfile_pkg::*;
    logic [3:0]  cnt;
    logic [31:0] res_q;
    logic        done_q;
    always @(posedge clk) begin
        wr_en <= 1'b0;
        wr_completes <= 1'b0;
        wr_data <= ~wr_data;
        if (!nrst) begin
            cnt <= 4'h0;
            wr_data <= 32'h0;
        end else if (start) begin
            cnt <= lat;
            wr_sel <= dst;
            res_q <= result;
            done_q <= completes;
        end else if (cnt == 4'h1) begin
            // Result lands after the latency; finishing write frees the register
            cnt <= 4'h0;
            wr_en <= 1'b1;
            wr_data <= res_q;
            wr_completes <= done_q;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Testbench for the windowed operand register file
`timescale 1ns/1ps
`default_nettype none
module tb;
    import regfile_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    operand_t    src1_sel = '0;
    operand_t    src2_sel = '0;
    operand_t    issue_dst = '0;
    operand_t    wr_sel;
    operand_t    m_dst = '0;
    logic [31:0] src1_data, src2_data, wr_data, frame_pointer, stack_pointer, mmr_rdata;
    logic [31:0] call_new_frame = '0, call_stack_ptr = '0, call_ret_ip = '0;
    logic [31:0] mmr_addr = '0, m_res = '0;
    logic        issue_valid = 1'b0, issue_has_dst = 1'b0, issue_multi = 1'b0;
    logic        call_req = 1'b0, ret_req = 1'b0, mmr_rd = 1'b0;
    logic        m_start = 1'b0, m_done = 1'b0;
    logic [3:0]  m_lat = 4'h1;
    logic        issue_hold, wr_en, wr_completes, frame_overflow, frame_underflow, mmr_hit;
    int          n_mismatch = 0;
    int          n_checks = 0;

    always #5 clk = ~clk;

    windowed_register_file DUT (.clk, .nrst, .src1_sel, .src2_sel, .src1_data, .src2_data,
        .issue_valid, .issue_has_dst, .issue_dst, .issue_multi, .issue_hold, .wr_en, .wr_sel,
        .wr_data, .wr_completes, .call_req, .call_new_frame, .call_stack_ptr, .call_ret_ip,
        .ret_req, .frame_overflow, .frame_underflow, .frame_pointer, .stack_pointer,
        .mmr_rd, .mmr_addr, .mmr_rdata, .mmr_hit);

    exec_unit_model partner (.clk, .nrst, .start(m_start), .lat(m_lat), .dst(m_dst),
        .result(m_res), .completes(m_done), .wr_en, .wr_sel, .wr_data, .wr_completes);

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic operand_t op(input logic [1:0] s, input logic [4:0] n);
        return '{s, n};
    endfunction

    task automatic start_op(input operand_t d, input logic [31:0] v, input logic [3:0] l,
                            input logic c);
        m_dst = d;
        m_res = v;
        m_lat = l;
        m_done = c;
        m_start = 1'b1;
        @(negedge clk);
        m_start = 1'b0;
    endtask

    task automatic write_reg(input operand_t d, input logic [31:0] v);
        start_op(d, v, 4'h1, 1'b0);
        repeat (2) @(negedge clk);
    endtask

    task automatic read_chk(input operand_t s, input logic [31:0] exp);
        src1_sel = s;
        #1;
        check(src1_data, exp);
        @(negedge clk);
    endtask

    // Requests stay up until the next frame_op, so back-to-back calls keep call_req high without a toggle
    task automatic frame_op(input logic c, input logic r, input logic [31:0] f);
        call_req = c;
        ret_req = r;
        call_new_frame = f;
        call_stack_ptr = f + 32'h40;
        call_ret_ip = ~f;
        @(negedge clk);
    endtask

    task automatic mmr_chk(input logic [31:0] a, input logic hit, input logic [31:0] exp);
        mmr_addr = a;
        mmr_rd = 1'b1;
        @(negedge clk);
        mmr_rd = 1'b0;
        check({31'h0, mmr_hit}, {31'h0, hit});
        check(mmr_rdata, exp);
    endtask

    initial begin
        #20000;
        n_mismatch++;
        wrap_up();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        read_chk(op(SPACE_GLOBAL, 5'h0), PART_IDENTITY_RESET);
        read_chk(op(SPACE_GLOBAL, 5'hF), WORD_ZERO);
        for (int i = 0; i < NUM_LITERALS; i++) begin
            src2_sel = op(SPACE_LITERAL, i[4:0]);
            #1;
            check(src2_data, 32'(i));
            @(negedge clk);
        end
        mmr_chk(PART_IDENTITY_WORD_ADDR, 1'b1, PART_IDENTITY_RESET);
        mmr_chk(PART_IDENTITY_WORD_ADDR + 32'h4, 1'b0, MAP_ERR_READ);
        write_reg(op(SPACE_GLOBAL, 5'h0), 32'h1234ABCD);
        read_chk(op(SPACE_GLOBAL, 5'h0), 32'h1234ABCD);
        mmr_chk(PART_IDENTITY_WORD_ADDR, 1'b1, PART_IDENTITY_RESET);
        write_reg(op(SPACE_GLOBAL, 5'hF), 32'h00001000);
        write_reg(op(SPACE_GLOBAL, 5'h3), 32'hCAFE0003);
        write_reg(op(SPACE_LOCAL, 5'h5), 32'hA5A50005);
        frame_op(1'b1, 1'b0, 32'h00002000);
        check(frame_pointer, 32'h00002000);
        check(stack_pointer, 32'h00002040);
        frame_op(1'b0, 1'b0, WORD_ZERO);
        read_chk(op(SPACE_LOCAL, 5'h0), 32'h00001000);
        read_chk(op(SPACE_LOCAL, 5'h1), 32'h00002040);
        read_chk(op(SPACE_LOCAL, 5'h2), 32'hFFFFDFFF);
        write_reg(op(SPACE_LOCAL, 5'h5), 32'h5A5A0005);
        read_chk(op(SPACE_LOCAL, 5'h5), 32'h5A5A0005);
        read_chk(op(SPACE_GLOBAL, 5'h3), 32'hCAFE0003);
        frame_op(1'b0, 1'b1, WORD_ZERO);
        check(frame_pointer, 32'h00001000);
        frame_op(1'b0, 1'b0, WORD_ZERO);
        read_chk(op(SPACE_LOCAL, 5'h5), 32'hA5A50005);
        // Multi-cycle result into g5, dependants held until it lands
        issue_valid = 1'b1;
        issue_has_dst = 1'b1;
        issue_multi = 1'b1;
        issue_dst = op(SPACE_GLOBAL, 5'h5);
        src1_sel = op(SPACE_LITERAL, 5'h1);
        start_op(op(SPACE_GLOBAL, 5'h5), 32'h0BAD0005, 4'h4, 1'b1);
        issue_has_dst = 1'b0;
        issue_multi = 1'b0;
        #1;
        check({31'h0, issue_hold}, 32'h0);
        @(negedge clk);
        src1_sel = op(SPACE_GLOBAL, 5'h6);
        #1;
        check({31'h0, issue_hold}, 32'h0);
        @(negedge clk);
        src1_sel = op(SPACE_GLOBAL, 5'h5);
        #1;
        check({31'h0, issue_hold}, 32'h1);
        check(src1_data, WORD_ZERO);
        repeat (2) @(negedge clk);
        #1;
        check({31'h0, issue_hold}, 32'h1);
        @(negedge clk);
        #1;
        check({31'h0, issue_hold}, 32'h0);
        check(src1_data, 32'h0BAD0005);
        @(negedge clk);
        issue_valid = 1'b0;
        frame_op(1'b0, 1'b1, WORD_ZERO);
        check({31'h0, frame_underflow}, 32'h1);
        frame_op(1'b1, 1'b0, 32'h00005000);
        frame_op(1'b0, 1'b1, WORD_ZERO);
        check(frame_pointer, 32'h00001000);
        check({31'h0, frame_underflow}, 32'h0);
        for (int i = 0; i < FRAME_DEPTH - 1; i++) begin
            frame_op(1'b1, 1'b0, 32'h00003000 + 32'(i));
            check({31'h0, frame_overflow}, 32'h0);
        end
        frame_op(1'b1, 1'b0, 32'h00004000);
        check({31'h0, frame_overflow}, 32'h1);
        check(frame_pointer, 32'h00003006);
        // Mid-run reset brings the identity word back after the overwrite
        nrst = 1'b0;
        frame_op(1'b0, 1'b0, WORD_ZERO);
        nrst = 1'b1;
        read_chk(op(SPACE_GLOBAL, 5'h0), PART_IDENTITY_RESET);
        check(frame_pointer, WORD_ZERO);
        wrap_up();
    end
endmodule
`default_nettype wire

/* logic/literal_expand.sv */
// Literal operand zero extension
`timescale 1ns/1ps
`default_nettype none
module literal_expand (
    // Literal number
    input  wire logic [4:0]  lit_num,
    // Expanded word
    output logic      [31:0] lit_word
);
    import regfile_pkg::*;
    assign lit_word = {27'h0000000, lit_num};
endmodule
`default_nettype wire

/* logic/regfile_pkg.sv */
// Constants and types shared by the operand register file
package regfile_pkg;
    localparam int NUM_GLOBALS         = 16;
    localparam int NUM_LOCALS          = 16;
    localparam int NUM_LITERALS        = 32;
    localparam int WORD_W              = 32;
    localparam int FRAME_DEPTH         = 8;
    localparam int FRAME_W             = 3;
    localparam logic [3:0] FRAME_PTR_IDX   = 4'hF;
    localparam logic [3:0] IDENT_IDX       = 4'h0;
    localparam logic [3:0] PREV_FRAME_IDX  = 4'h0;
    localparam logic [3:0] STACK_PTR_IDX   = 4'h1;
    localparam logic [3:0] RET_IP_IDX      = 4'h2;
    localparam logic [31:0] PART_IDENTITY_WORD_ADDR = 32'hFF008710;
    // Identity value is arbitrary
    localparam logic [31:0] PART_IDENTITY_RESET = 32'h00A5C301;
    localparam logic [31:0] WORD_ZERO  = 32'h00000000;
    localparam logic [31:0] MAP_ERR_READ = 32'h00000000;
    localparam logic [1:0] SPACE_GLOBAL  = 2'h0;
    localparam logic [1:0] SPACE_LOCAL   = 2'h1;
    localparam logic [1:0] SPACE_LITERAL = 2'h2;
    // Operand select: space and five-bit number
    typedef struct packed {
        logic [1:0] space;
        logic [4:0] num;
    } operand_t;
endpackage

/* logic/scoreboard.sv */
// Per-register pending-write scoreboard
`timescale 1ns/1ps
`default_nettype none
module scoreboard (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Issue and completion
    input  wire logic        set_en,
    input  wire logic [4:0]  set_idx,
    input  wire logic        clr_en,
    input  wire logic [4:0]  clr_idx,
    input  wire logic        flush_locals,
    // Pending bits
    output logic      [31:0] busy
);
    import regfile_pkg::*;
    typedef struct packed {
        logic [31:0] bits;
    } sb_state_t;
    sb_state_t st_reg;
    sb_state_t st_next;
    always_comb begin
        st_next = st_reg;
        if (flush_locals) begin
            st_next.bits[31:16] = 16'h0000;
        end
        if (clr_en) begin
            st_next.bits[clr_idx] = 1'b0;
        end
        if (set_en) begin
            st_next.bits[set_idx] = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign busy = st_reg.bits;
    chk_set_marks_busy: assert property (@(posedge clk) disable iff (!nrst)
        set_en |=> busy[$past(set_idx)])
        else $error("issued destination not marked busy");
    chk_clear_releases: assert property (@(posedge clk) disable iff (!nrst)
        (clr_en && !(set_en && set_idx == clr_idx)) |=> !busy[$past(clr_idx)])
        else $error("completed destination still busy");
endmodule
`default_nettype wire

/* logic/windowed_register_file.sv */
// Operand register file with windowed locals and scoreboard
// ****************************************************************
// Overview of operation
// - Sixteen globals, sixteen locals, thirty-two literals
// - Globals are 32 bits, kept across calls except the frame pointer
// - Top global holds the frame pointer
// - Reset puts identity word into global zero
// - Identity word also readable at fixed address
// - Call allocates fresh locals, saves caller's
// - Return releases callee's local set
// - Locals 0-2: previous frame, stack, return
// - New local sets are not cleared
// - Multi-cycle issue marks destination register busy
// - Independent instructions proceed during long operations
// - Reads of busy registers are held
// - Literals are zero-extended values 0 to 31
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module windowed_register_file (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Source operands
    input  wire regfile_pkg::operand_t src1_sel,
    input  wire regfile_pkg::operand_t src2_sel,
    output logic      [31:0]          src1_data,
    output logic      [31:0]          src2_data,
    // Issue of an instruction
    input  wire logic                 issue_valid,
    input  wire logic                 issue_has_dst,
    input  wire regfile_pkg::operand_t issue_dst,
    input  wire logic                 issue_multi,
    output logic                      issue_hold,
    // Result write
    input  wire logic                 wr_en,
    input  wire regfile_pkg::operand_t wr_sel,
    input  wire logic [31:0]          wr_data,
    input  wire logic                 wr_completes,
    // Procedure call and return
    input  wire logic                 call_req,
    input  wire logic [31:0]          call_new_frame,
    input  wire logic [31:0]          call_stack_ptr,
    input  wire logic [31:0]          call_ret_ip,
    input  wire logic                 ret_req,
    output logic                      frame_overflow,
    output logic                      frame_underflow,
    output logic      [31:0]          frame_pointer,
    output logic      [31:0]          stack_pointer,
    // Memory-mapped read
    input  wire logic                 mmr_rd,
    input  wire logic [31:0]          mmr_addr,
    output logic      [31:0]          mmr_rdata,
    output logic                      mmr_hit
);
    import regfile_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NUM_GLOBALS-1:0][31:0] globals;
        logic [FRAME_W-1:0]           depth;
        logic                         ovf;
        logic                         unf;
        logic [31:0]                  rdata;
        logic                         hit;
    } rf_state_t;
    rf_state_t st_reg;
    rf_state_t st_next;

    // Local frames live in an array, one set per call depth
    logic [31:0] locals [FRAME_DEPTH][NUM_LOCALS];
    logic [31:0] busy;
    logic [31:0] lit1;
    logic [31:0] lit2;
    logic        src1_busy;
    logic        src2_busy;
    logic        dst_busy;
    logic        issue_ok;
    logic        do_call;
    logic        do_ret;
    logic [FRAME_W-1:0] next_depth;

    // ****************************************************************
    // Literals and scoreboard
    // ****************************************************************
    literal_expand u_lit1 (
        .lit_num  (src1_sel.num),
        .lit_word (lit1)
    );
    literal_expand u_lit2 (
        .lit_num  (src2_sel.num),
        .lit_word (lit2)
    );

    function automatic logic is_busy(input operand_t op, input logic [31:0] b);
        logic r;
        r = 1'b0;
        if (op.space == SPACE_GLOBAL) begin
            r = b[{1'b0, op.num[3:0]}];
        end else if (op.space == SPACE_LOCAL) begin
            r = b[{1'b1, op.num[3:0]}];
        end
        return r;
    endfunction

    assign src1_busy = is_busy(src1_sel, busy);
    assign src2_busy = is_busy(src2_sel, busy);
    assign dst_busy  = issue_has_dst && is_busy(issue_dst, busy);
    // Busy only blocks dependent instructions
    assign issue_hold = issue_valid && (src1_busy || src2_busy || dst_busy);
    assign issue_ok   = issue_valid && !issue_hold;

    scoreboard u_sb (
        .clk          (clk),
        .nrst         (nrst),
        .set_en       (issue_ok && issue_has_dst && issue_multi
                       && issue_dst.space != SPACE_LITERAL),
        .set_idx      ({issue_dst.space == SPACE_LOCAL, issue_dst.num[3:0]}),
        .clr_en       (wr_en && wr_completes),
        .clr_idx      ({wr_sel.space == SPACE_LOCAL, wr_sel.num[3:0]}),
        .flush_locals (do_call || do_ret),
        .busy         (busy)
    );

    // ****************************************************************
    // Operand reads
    // ****************************************************************
    function automatic logic [31:0] read_op(input operand_t op, input logic [31:0] lit,
                                            input logic [31:0] gv, input logic [31:0] lv);
        logic [31:0] r;
        r = WORD_ZERO;
        case (op.space)
            SPACE_GLOBAL:  r = gv;
            SPACE_LOCAL:   r = lv;
            SPACE_LITERAL: r = lit;
            default:       r = WORD_ZERO;
        endcase
        return r;
    endfunction

    assign src1_data = read_op(src1_sel, lit1, st_reg.globals[src1_sel.num[3:0]],
                               locals[st_reg.depth][src1_sel.num[3:0]]);
    assign src2_data = read_op(src2_sel, lit2, st_reg.globals[src2_sel.num[3:0]],
                               locals[st_reg.depth][src2_sel.num[3:0]]);

    // ****************************************************************
    // Frame management
    // ****************************************************************
    assign do_call = call_req && (st_reg.depth != FRAME_W'(FRAME_DEPTH - 1));
    assign do_ret  = ret_req && !call_req && (st_reg.depth != '0);
    assign next_depth = FRAME_W'(st_reg.depth + 3'h1);

    always_comb begin
        st_next = st_reg;
        st_next.ovf = call_req && !do_call;
        st_next.unf = ret_req && !call_req && !do_ret;
        // Call and return change only the frame-pointer global
        if (wr_en && wr_sel.space == SPACE_GLOBAL) begin
            st_next.globals[wr_sel.num[3:0]] = wr_data;
        end
        if (do_call) begin
            st_next.depth = next_depth;
            st_next.globals[FRAME_PTR_IDX] = call_new_frame;
        end else if (do_ret) begin
            st_next.depth = FRAME_W'(st_reg.depth - 3'h1);
            st_next.globals[FRAME_PTR_IDX] = locals[st_reg.depth][PREV_FRAME_IDX];
        end
        st_next.hit   = mmr_rd && mmr_addr == PART_IDENTITY_WORD_ADDR;
        st_next.rdata = st_next.hit ? PART_IDENTITY_RESET : MAP_ERR_READ;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.globals[IDENT_IDX] <= PART_IDENTITY_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Local storage has no reset: new sets start with stale contents
    always_ff @(posedge clk) begin
        if (do_call) begin
            locals[next_depth][PREV_FRAME_IDX] <= st_reg.globals[FRAME_PTR_IDX];
            locals[next_depth][STACK_PTR_IDX]  <= call_stack_ptr;
            locals[next_depth][RET_IP_IDX]     <= call_ret_ip;
        end else if (wr_en && wr_sel.space == SPACE_LOCAL && !do_ret) begin
            locals[st_reg.depth][wr_sel.num[3:0]] <= wr_data;
        end
    end

    assign frame_pointer   = st_reg.globals[FRAME_PTR_IDX];
    assign stack_pointer   = locals[st_reg.depth][STACK_PTR_IDX];
    assign frame_overflow  = st_reg.ovf;
    assign frame_underflow = st_reg.unf;
    assign mmr_rdata       = st_reg.rdata;
    assign mmr_hit         = st_reg.hit;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence call_seq;
        call_req && st_reg.depth != FRAME_W'(FRAME_DEPTH - 1);
    endsequence
    sequence ret_seq;
        ret_req && !call_req && st_reg.depth != '0;
    endsequence
    sequence full_call_seq;
        call_req && st_reg.depth == FRAME_W'(FRAME_DEPTH - 1);
    endsequence
    sequence empty_ret_seq;
        ret_req && !call_req && st_reg.depth == '0;
    endsequence
    sequence global_wr_seq;
        wr_en && wr_sel.space == SPACE_GLOBAL && !call_req && !ret_req;
    endsequence
    sequence local_wr_seq;
        wr_en && wr_sel.space == SPACE_LOCAL && !call_req && !ret_req;
    endsequence

    chk_call_depth_up: assert property (@(posedge clk) disable iff (!nrst)
        call_seq |=> st_reg.depth == FRAME_W'($past(st_reg.depth) + 3'h1))
        else $error("call did not allocate a frame");
    chk_ret_depth_down: assert property (@(posedge clk) disable iff (!nrst)
        ret_seq |=> st_reg.depth == FRAME_W'($past(st_reg.depth) - 3'h1))
        else $error("return did not release a frame");
    chk_call_fp_load: assert property (@(posedge clk) disable iff (!nrst)
        call_seq |=> frame_pointer == $past(call_new_frame))
        else $error("frame pointer not loaded on call");
    chk_call_ret_link: assert property (@(posedge clk) disable iff (!nrst)
        call_seq ##1 ret_seq |=> frame_pointer == $past(frame_pointer, 2))
        else $error("return did not restore previous frame");
    chk_global_persist: assert property (@(posedge clk) disable iff (!nrst)
        (call_seq or ret_seq) and !wr_en
        |=> st_reg.globals[1] == $past(st_reg.globals[1]))
        else $error("global changed across call");
    chk_ident_reset: assert property (@(posedge clk)
        !nrst |=> st_reg.globals[IDENT_IDX] == PART_IDENTITY_RESET)
        else $error("identity word missing after reset");
    chk_mmr_ident: assert property (@(posedge clk) disable iff (!nrst)
        mmr_rd && mmr_addr == PART_IDENTITY_WORD_ADDR
        |=> mmr_hit && mmr_rdata == PART_IDENTITY_RESET)
        else $error("identity register read wrong");
    chk_hold_busy: assert property (@(posedge clk) disable iff (!nrst)
        issue_valid && src1_sel.space == SPACE_GLOBAL && busy[{1'b0, src1_sel.num[3:0]}]
        |-> issue_hold)
        else $error("busy source not held");
    chk_free_issue: assert property (@(posedge clk) disable iff (!nrst)
        issue_valid && src1_sel.space == SPACE_LITERAL && src2_sel.space == SPACE_LITERAL
        && !issue_has_dst |-> !issue_hold)
        else $error("independent instruction held");
    chk_literal_ext: assert property (@(posedge clk) disable iff (!nrst)
        src1_sel.space == SPACE_LITERAL |-> src1_data == {27'h0000000, src1_sel.num})
        else $error("literal not zero extended");

    // ****************************************************************
    // Frame, write and read checks
    // ****************************************************************
    chk_call_full: assert property (@(posedge clk) disable iff (!nrst)
        full_call_seq |=> frame_overflow && $stable(st_reg.depth))
        else $error("refused call changed the frame depth");
    chk_ret_empty: assert property (@(posedge clk) disable iff (!nrst)
        empty_ret_seq |=> frame_underflow && st_reg.depth == '0)
        else $error("refused return changed the frame depth");
    chk_call_link_save: assert property (@(posedge clk) disable iff (!nrst)
        call_seq |=> locals[st_reg.depth][PREV_FRAME_IDX] == $past(frame_pointer)
        && stack_pointer == $past(call_stack_ptr)
        && locals[st_reg.depth][RET_IP_IDX] == $past(call_ret_ip))
        else $error("call did not fill the link slots");
    chk_ret_fp_restore: assert property (@(posedge clk) disable iff (!nrst)
        ret_seq |=> frame_pointer == $past(locals[st_reg.depth][PREV_FRAME_IDX]))
        else $error("return did not restore the frame pointer");
    chk_global_write: assert property (@(posedge clk) disable iff (!nrst)
        global_wr_seq |=> st_reg.globals[$past(wr_sel.num[3:0])] == $past(wr_data))
        else $error("global register write lost");
    chk_local_write: assert property (@(posedge clk) disable iff (!nrst)
        local_wr_seq |=> locals[st_reg.depth][$past(wr_sel.num[3:0])] == $past(wr_data))
        else $error("local register write lost");
    chk_ident_kept: assert property (@(posedge clk) disable iff (!nrst)
        !(wr_en && wr_sel.space == SPACE_GLOBAL && wr_sel.num[3:0] == IDENT_IDX)
        |=> $stable(st_reg.globals[IDENT_IDX]))
        else $error("identity word changed without a write");
    chk_mmr_miss: assert property (@(posedge clk) disable iff (!nrst)
        !(mmr_rd && mmr_addr == PART_IDENTITY_WORD_ADDR)
        |=> !mmr_hit && mmr_rdata == MAP_ERR_READ)
        else $error("identity register hit on wrong address");
    chk_hold_src2: assert property (@(posedge clk) disable iff (!nrst)
        issue_valid && src2_sel.space == SPACE_GLOBAL && busy[{1'b0, src2_sel.num[3:0]}]
        |-> issue_hold)
        else $error("busy second source not held");
    chk_hold_local: assert property (@(posedge clk) disable iff (!nrst)
        issue_valid && src1_sel.space == SPACE_LOCAL && busy[{1'b1, src1_sel.num[3:0]}]
        |-> issue_hold)
        else $error("busy local source not held");
    chk_literal_second: assert property (@(posedge clk) disable iff (!nrst)
        src2_sel.space == SPACE_LITERAL |-> src2_data == {27'h0000000, src2_sel.num})
        else $error("second literal not zero extended");
    chk_unused_space: assert property (@(posedge clk) disable iff (!nrst)
        src1_sel.space == 2'h3 |-> src1_data == WORD_ZERO)
        else $error("unused operand space not read as zero");
endmodule
`default_nettype wire
